// ===== hw/swd_watchdog.sv
// module: watchdog with window, timeout and off modes behind an AXI4-Lite slave
`timescale 1ns/100ps

// Summary of operation
// - writing one clears a pending interrupt flag
// - timer runs from the always-on clock
// - three modes: window, timeout, off
// - period field selects period, default 128 ms
// - every control write outside off mode is a trigger
// - window: trigger in first half resets
// - window: trigger in second half restarts
// - timeout: any trigger before overflow restarts
// - overflow after full period without trigger
// - window overflow causes system reset
// - timeout overflow with flag pending resets
// - disable pin change in normal/standby resets
// - mode bit change in normal resets
// - watchdog reset restores period code 100
// - disable pin high turns watchdog off
// - mode bit one in standby turns off
// - pending interrupt re-enables watchdog from bit
// - standby mode-bit write ignored while interrupts pending
// - window mode: pin low, normal, bit zero
// - timeout overflow without flag sets flag
// - timeout mode: standby/0 or normal/1
// - off in off, overtemp, sleep chip modes
module swd_watchdog #(
  parameter logic [31:0] TICKS_PER_MS = 32'(swd_pkg::SWD_TICKS_PER_MS)
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire swd_pkg::swd_axi_req_t i_axi,
  output swd_pkg::swd_axi_rsp_t o_axi,
  input wire swd_pkg::swd_chip_mode_t i_chip_mode,
  input wire logic i_wd_disable_pin,
  input wire logic i_ext_irq_pending,
  output logic o_wd_rst_pulse,
  output logic o_cyclic_irq_flag
);

  // ****************************************
  // state
  // ****************************************
  swd_pkg::swd_axi_rsp_t axi_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [3:0] waddr_reg;
  logic waddr_ok_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [2:0] period_sel_reg;
  logic wd_mode_ctrl_reg;
  logic cyclic_irq_flag_reg;
  logic [31:0] timer_reg;
  logic pin_prev_reg;
  logic pin_seen_reg;
  swd_pkg::swd_wd_mode_t mode_prev_reg;
  logic [4:0] cause_reg;
  logic rst_pulse_reg;

  swd_pkg::swd_wd_mode_t wd_mode;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_int;
  logic lane0;
  logic irq_any;
  logic in_normal;
  logic in_standby;
  logic [31:0] period;
  logic [31:0] half;
  logic trig;
  logic early;
  logic ovf;
  logic ovf_win;
  logic ovf_ci;
  logic ovf_set_ci;
  logic pin_change;
  logic wmc_change;
  logic wmc_blocked;
  logic wd_rst;
  logic [31:0] rdata_next;
  logic rd_ok;

  // check that a byte address is an in-range, word-aligned offset
  function automatic logic addr_ok(input logic [31:0] a);
    return (a[31:4] == 28'h0000000) && (a[1:0] == 2'b00);
  endfunction : addr_ok

  // ****************************************
  // AXI4-Lite write channels
  // ****************************************
  assign wr_fire = aw_have_reg && w_have_reg && !axi_reg.bvalid;
  assign lane0 = wstrb_reg[0];
  assign wr_ctrl = wr_fire && waddr_ok_reg && (waddr_reg == swd_pkg::SWD_OFS_CTRL);
  assign wr_int = wr_fire && waddr_ok_reg && (waddr_reg == swd_pkg::SWD_OFS_INT);

  // address and data are latched independently, in either order
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      waddr_reg <= 4'h0;
      waddr_ok_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (i_axi.awvalid && axi_reg.awready) begin
        aw_have_reg <= 1'b1;
        waddr_reg <= i_axi.awaddr[3:0];
        waddr_ok_reg <= addr_ok(i_axi.awaddr);
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
      if (i_axi.wvalid && axi_reg.wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= i_axi.wdata;
        wstrb_reg <= i_axi.wstrb;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // write response; ready drops while a channel holds an item
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      axi_reg.awready <= 1'b0;
      axi_reg.wready <= 1'b0;
      axi_reg.bvalid <= 1'b0;
      axi_reg.bresp <= swd_pkg::SWD_RESP_OKAY;
    end else begin
      axi_reg.awready <= !aw_have_reg && !(i_axi.awvalid && axi_reg.awready)
                         && !axi_reg.bvalid;
      axi_reg.wready <= !w_have_reg && !(i_axi.wvalid && axi_reg.wready)
                        && !axi_reg.bvalid;
      if (wr_fire) begin
        axi_reg.bvalid <= 1'b1;
        axi_reg.bresp <= waddr_ok_reg ? swd_pkg::SWD_RESP_OKAY : swd_pkg::SWD_RESP_SLVERR;
      end else if (i_axi.bready) begin
        axi_reg.bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channels
  // ****************************************
  // read mux; reserved bits read zero
  always_comb begin
    rdata_next = 32'h00000000;
    rd_ok = addr_ok(i_axi.araddr);
    case (i_axi.araddr[3:0])
      swd_pkg::SWD_OFS_CTRL: begin
        rdata_next[swd_pkg::SWD_NWP_LSB +: swd_pkg::SWD_NWP_W] = period_sel_reg;
        rdata_next[swd_pkg::SWD_WMC_BIT] = wd_mode_ctrl_reg;
        rdata_next[swd_pkg::SWD_MODE_LSB +: 3] = wd_mode;
        rdata_next[swd_pkg::SWD_PIN_BIT] = i_wd_disable_pin;
      end
      swd_pkg::SWD_OFS_INT: begin
        rdata_next[swd_pkg::SWD_CI_BIT] = cyclic_irq_flag_reg;
        rdata_next[swd_pkg::SWD_EXT_BIT] = i_ext_irq_pending;
      end
      swd_pkg::SWD_OFS_STAT: begin
        rdata_next[2:0] = i_chip_mode;
        rdata_next[swd_pkg::SWD_CAUSE_LSB +: 5] = cause_reg;
      end
      swd_pkg::SWD_OFS_TIMER: rdata_next = timer_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  // one read at a time, answered the cycle after the address is taken
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      axi_reg.arready <= 1'b0;
      axi_reg.rvalid <= 1'b0;
      axi_reg.rdata <= 32'h00000000;
      axi_reg.rresp <= swd_pkg::SWD_RESP_OKAY;
    end else begin
      axi_reg.arready <= !axi_reg.rvalid && !(i_axi.arvalid && axi_reg.arready);
      if (i_axi.arvalid && axi_reg.arready) begin
        axi_reg.rvalid <= 1'b1;
        axi_reg.rdata <= rd_ok ? rdata_next : 32'h00000000;
        axi_reg.rresp <= rd_ok ? swd_pkg::SWD_RESP_OKAY : swd_pkg::SWD_RESP_SLVERR;
      end else if (i_axi.rready) begin
        axi_reg.rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // mode selection
  // ****************************************
  assign in_normal = (i_chip_mode == swd_pkg::SWD_CHIP_NORMAL);
  assign in_standby = (i_chip_mode == swd_pkg::SWD_CHIP_STANDBY);
  assign irq_any = cyclic_irq_flag_reg || i_ext_irq_pending;

  always_comb begin
    // bit set in standby is off
    if (i_wd_disable_pin || !(in_normal || in_standby)
        || (in_standby && wd_mode_ctrl_reg)) begin
      wd_mode = swd_pkg::SWD_WD_OFF;
    end else if (in_normal && !wd_mode_ctrl_reg) begin
      wd_mode = swd_pkg::SWD_WD_WINDOW;
    end else begin
      wd_mode = swd_pkg::SWD_WD_TIMEOUT;
    end
  end

  // ****************************************
  // watchdog events
  // ****************************************
  // code-to-period table
  assign period = swd_pkg::swd_period_cycles(period_sel_reg, TICKS_PER_MS);
  assign half = period >> 1;
  // any control write outside off mode is a trigger
  assign trig = wr_ctrl && (wd_mode != swd_pkg::SWD_WD_OFF);
  assign early = trig && (wd_mode == swd_pkg::SWD_WD_WINDOW) && (timer_reg < half);
  // full period without trigger; >= copes with a shortened period
  assign ovf = (wd_mode != swd_pkg::SWD_WD_OFF) && !trig && (timer_reg >= period - 32'h1);
  assign ovf_win = ovf && (wd_mode == swd_pkg::SWD_WD_WINDOW);
  assign ovf_ci = ovf && (wd_mode == swd_pkg::SWD_WD_TIMEOUT) && cyclic_irq_flag_reg;
  assign ovf_set_ci = ovf && (wd_mode == swd_pkg::SWD_WD_TIMEOUT) && !cyclic_irq_flag_reg;
  // pin edge in normal or standby
  assign pin_change = pin_seen_reg && (i_wd_disable_pin != pin_prev_reg)
                      && (in_normal || in_standby);
  // standby mode-bit write blocked while interrupts pend
  assign wmc_blocked = in_standby && irq_any;
  // accepted bit change in normal mode
  assign wmc_change = wr_ctrl && lane0 && in_normal
                      && (wdata_reg[swd_pkg::SWD_WMC_BIT] != wd_mode_ctrl_reg);
  assign wd_rst = early || ovf_win || ovf_ci || pin_change || wmc_change;

  // ****************************************
  // timer
  // ****************************************
  // counts the always-running system clock
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      timer_reg <= 32'h00000000;
      mode_prev_reg <= swd_pkg::SWD_WD_OFF;
    end else begin
      mode_prev_reg <= wd_mode;
      if (wd_mode == swd_pkg::SWD_WD_OFF || mode_prev_reg == swd_pkg::SWD_WD_OFF) begin
        timer_reg <= 32'h00000000;
      end else if (trig || ovf || wd_rst) begin
        timer_reg <= 32'h00000000;
      end else begin
        timer_reg <= timer_reg + 32'h1;
      end
    end
  end

  // ****************************************
  // control register fields
  // ****************************************
  // period select, default 128 ms
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      period_sel_reg <= swd_pkg::SWD_NWP_DEFAULT;
    end else if (wd_rst) begin
      period_sel_reg <= swd_pkg::SWD_NWP_DEFAULT;
    end else if (wr_ctrl && lane0) begin
      period_sel_reg <= wdata_reg[swd_pkg::SWD_NWP_LSB +: swd_pkg::SWD_NWP_W];
    end
  end

  // mode-control bit
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wd_mode_ctrl_reg <= 1'b0;
    end else if (wr_ctrl && lane0 && !wmc_blocked) begin
      wd_mode_ctrl_reg <= wdata_reg[swd_pkg::SWD_WMC_BIT];
    // pending interrupt re-enables from standby off
    end else if (in_standby && wd_mode_ctrl_reg && irq_any) begin
      wd_mode_ctrl_reg <= 1'b0;
    end
  end

  // write one clears; a same-cycle set wins
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cyclic_irq_flag_reg <= 1'b0;
    end else if (ovf_set_ci) begin
      cyclic_irq_flag_reg <= 1'b1;
    end else if (wr_int && lane0 && wdata_reg[swd_pkg::SWD_CI_BIT]) begin
      cyclic_irq_flag_reg <= 1'b0;
    end
  end

  // pin history; first sample after reset is a strap, not an edge
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pin_prev_reg <= 1'b0;
      pin_seen_reg <= 1'b0;
    end else begin
      pin_prev_reg <= i_wd_disable_pin;
      pin_seen_reg <= 1'b1;
    end
  end

  // reset request pulse and last cause
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rst_pulse_reg <= 1'b0;
      cause_reg <= swd_pkg::SWD_CAUSE_NONE;
    end else begin
      rst_pulse_reg <= wd_rst;
      if (wd_rst) begin
        cause_reg <= {wmc_change, pin_change, ovf_ci, ovf_win, early};
      end
    end
  end

  assign o_axi = axi_reg;
  assign o_wd_rst_pulse = rst_pulse_reg;
  assign o_cyclic_irq_flag = cyclic_irq_flag_reg;

  // ****************************************
  // checks
  // ****************************************
  chk_early_trig: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    early |=> o_wd_rst_pulse && cause_reg[0])
    else $error("early trigger gave no reset");
  chk_open_trig: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (trig && wd_mode == swd_pkg::SWD_WD_WINDOW && timer_reg >= half
      && !pin_change && !wmc_change) |=> !o_wd_rst_pulse && timer_reg == 32'h0)
    else $error("open window trigger gave reset");
  chk_trig_restart: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    trig |=> timer_reg == 32'h0)
    else $error("trigger did not restart timer");
  chk_window_ovf: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ovf_win |=> o_wd_rst_pulse && period_sel_reg == swd_pkg::SWD_NWP_DEFAULT)
    else $error("window overflow gave no reset");
  chk_ci_reset: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ovf_ci |=> o_wd_rst_pulse && cause_reg[2])
    else $error("overflow with flag gave no reset");
  chk_ci_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ovf_set_ci |=> o_cyclic_irq_flag && !o_wd_rst_pulse)
    else $error("timeout overflow did not set flag");
  chk_pin_edge: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (pin_seen_reg && $changed(i_wd_disable_pin) && (in_normal || in_standby))
      |=> o_wd_rst_pulse)
    else $error("pin change gave no reset");
  chk_wmc_change: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    wmc_change |=> o_wd_rst_pulse && cause_reg[4])
    else $error("mode bit change gave no reset");
  chk_nwp_default: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    wd_rst |=> period_sel_reg == swd_pkg::SWD_NWP_DEFAULT)
    else $error("period code not restored");
  chk_pin_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_wd_disable_pin |-> wd_mode == swd_pkg::SWD_WD_OFF)
    else $error("pin high but watchdog running");
  chk_wmc_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_ctrl && wmc_blocked) |=> $stable(wd_mode_ctrl_reg))
    else $error("blocked mode bit write took effect");
  chk_flag_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (wr_int && lane0 && wdata_reg[swd_pkg::SWD_CI_BIT] && !ovf_set_ci) |=> !o_cyclic_irq_flag)
    else $error("write one did not clear flag");
  chk_fresh_start: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (mode_prev_reg == swd_pkg::SWD_WD_OFF && wd_mode != swd_pkg::SWD_WD_OFF)
      |=> timer_reg == 32'h0)
    else $error("period not fresh after off");

endmodule : swd_watchdog

// ===== hw/swd_pkg.sv
// package: constants, modes and bus carriers for the window/timeout watchdog
package swd_pkg;

  // ****************************************
  // register map and field layout
  // ****************************************
  localparam logic [3:0] SWD_OFS_CTRL = 4'h0;
  localparam logic [3:0] SWD_OFS_INT = 4'h4;
  localparam logic [3:0] SWD_OFS_STAT = 4'h8;
  localparam logic [3:0] SWD_OFS_TIMER = 4'hC;
  localparam int SWD_NWP_LSB = 0;
  localparam int SWD_NWP_W = 3;
  localparam int SWD_WMC_BIT = 3;
  localparam int SWD_MODE_LSB = 4;
  localparam int SWD_PIN_BIT = 7;
  localparam int SWD_CI_BIT = 0;
  localparam int SWD_EXT_BIT = 1;
  localparam int SWD_CAUSE_LSB = 4;
  localparam logic [2:0] SWD_NWP_DEFAULT = 3'h4;
  localparam logic [4:0] SWD_CAUSE_NONE = 5'h00;
  localparam logic [1:0] SWD_RESP_OKAY = 2'h0;
  localparam logic [1:0] SWD_RESP_SLVERR = 2'h2;

  // ****************************************
  // timing
  // ****************************************
  localparam int SWD_CLK_HZ = 10000000;
  localparam int SWD_MS_PER_S = 1000;
  localparam int SWD_TICKS_PER_MS = SWD_CLK_HZ / SWD_MS_PER_S;
  localparam int SWD_BASE_PERIOD_MS = 8;
  localparam int SWD_DEFAULT_PERIOD_MS = 128;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    SWD_WD_OFF = 3'b001,
    SWD_WD_WINDOW = 3'b010,
    SWD_WD_TIMEOUT = 3'b100
  } swd_wd_mode_t;

  typedef enum logic [2:0] {
    SWD_CHIP_OFF = 3'h0,
    SWD_CHIP_OVERTEMP = 3'h1,
    SWD_CHIP_SLEEP = 3'h2,
    SWD_CHIP_STANDBY = 3'h3,
    SWD_CHIP_NORMAL = 3'h4
  } swd_chip_mode_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } swd_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } swd_axi_rsp_t;

  // period in clock cycles: code 100 gives 8 << 4 = 128 ms
  function automatic logic [31:0] swd_period_cycles(input logic [2:0] code,
                                                   input logic [31:0] ticks);
    logic [31:0] ms;
    ms = 32'(SWD_BASE_PERIOD_MS) << code;
    return 32'(ms * ticks);
  endfunction : swd_period_cycles

endpackage : swd_pkg

// ===== tb/swd_host_model.sv
// host model: AXI4-Lite master standing in for the servicing microcontroller
`timescale 1ns/100ps
module swd_host_model (
  input wire logic i_clk_sys,
  input wire swd_pkg::swd_axi_rsp_t i_axi,
  output swd_pkg::swd_axi_req_t o_axi
);
  // ****************************************
  // bus cycles
  // ****************************************
  // idle bus from time zero so the slave never sees unknown valids
  initial begin
    o_axi = '0;
  end

  // trigger by write: each call lands on the slave as exactly one write
  task automatic wr(input logic [31:0] addr, input logic [31:0] data, output logic [1:0] resp);
    resp = 2'bxx; // stays unknown if the slave never answers
    @(posedge i_clk_sys);
    o_axi.awvalid <= 1'b1;
    o_axi.awaddr <= addr;
    o_axi.wvalid <= 1'b1;
    o_axi.wdata <= data;
    o_axi.wstrb <= 4'hF;
    o_axi.bready <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(posedge i_clk_sys);
      // released payload shows the inverse, never a stale copy
      if (o_axi.awvalid && i_axi.awready) begin
        o_axi.awvalid <= 1'b0;
        o_axi.awaddr <= ~addr;
      end
      if (o_axi.wvalid && i_axi.wready) begin
        o_axi.wvalid <= 1'b0;
        o_axi.wdata <= ~data;
      end
      if (i_axi.bvalid) begin
        resp = i_axi.bresp;
        o_axi.bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  // single read; data and response stay unknown on a hang
  task automatic rd(input logic [31:0] addr, output logic [31:0] data, output logic [1:0] resp);
    resp = 2'bxx;
    data = 32'hxxxxxxxx;
    @(posedge i_clk_sys);
    o_axi.arvalid <= 1'b1;
    o_axi.araddr <= addr;
    o_axi.rready <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(posedge i_clk_sys);
      if (o_axi.arvalid && i_axi.arready) begin
        o_axi.arvalid <= 1'b0;
        o_axi.araddr <= ~addr;
      end
      if (i_axi.rvalid) begin
        data = i_axi.rdata;
        resp = i_axi.rresp;
        o_axi.rready <= 1'b0;
        break;
      end
    end
  endtask : rd
endmodule : swd_host_model

// ===== tb/testbench.sv
// testbench: mode table, window and timeout timing, pin and mode-bit resets
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) begin \
      num_errors++; \
      $display("FAIL %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module testbench;
  typedef struct packed {
    logic [2:0] chip;
    logic pin;
    logic wd_mode_ctrl;
    logic [2:0] mode;
  } swd_row_t;
  localparam logic [31:0] TPMS = 32'h4; // code 0 gives 32 cycles, code 4 gives 512
  logic i_clk_sys;
  logic i_sys_rst;
  swd_pkg::swd_axi_req_t axi_req;
  swd_pkg::swd_axi_rsp_t axi_rsp;
  swd_pkg::swd_chip_mode_t chip;
  logic pin;
  logic ext_irq;
  logic rst_pulse;
  logic ci_flag;
  logic [31:0] rdat;
  logic [1:0] resp;
  int num_errors = 0;
  int n_checks = 0;
  int n_pulse = 0;
  swd_row_t rows [8] = '{
    '{3'h4, 1'h0, 1'h0, 3'h2}, // normal window
    '{3'h4, 1'h0, 1'h1, 3'h4}, // normal timeout
    '{3'h3, 1'h0, 1'h0, 3'h4}, // standby timeout
    '{3'h3, 1'h0, 1'h1, 3'h1}, // standby off
    '{3'h4, 1'h1, 1'h0, 3'h1}, // pin off
    '{3'h2, 1'h0, 1'h0, 3'h1}, // sleep off
    '{3'h1, 1'h0, 1'h0, 3'h1}, // overtemp off
    '{3'h0, 1'h0, 1'h0, 3'h1} // chip off
  };

  swd_watchdog #(.TICKS_PER_MS(TPMS)) uut (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_axi(axi_req),
    .o_axi(axi_rsp),
    .i_chip_mode(chip),
    .i_wd_disable_pin(pin),
    .i_ext_irq_pending(ext_irq),
    .o_wd_rst_pulse(rst_pulse),
    .o_cyclic_irq_flag(ci_flag)
  );

  swd_host_model host (
    .i_clk_sys(i_clk_sys),
    .i_axi(axi_rsp),
    .o_axi(axi_req)
  );

  // ****************************************
  // clock, reset pulse tally, hang guard
  // ****************************************
  // 10 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  // counts reset requests; cleared with the design, so after the mid-run reset the count runs on across phases
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      n_pulse <= 0;
    end else if (rst_pulse === 1'b1) begin
      n_pulse <= n_pulse + 1;
    end
  end

  // a hang anywhere ends here instead of running forever
  initial begin
    for (int n = 0; n < 50000; n++) begin
      @(posedge i_clk_sys);
    end
    num_errors++;
    complete_run();
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : idle

  task automatic setm(input swd_pkg::swd_chip_mode_t c, input logic p, input logic q);
    @(posedge i_clk_sys);
    chip <= c;
    pin <= p;
    ext_irq <= q;
    idle(2);
  endtask : setm

  // control write: mode bit on top of the period code
  task automatic ctl(input logic [3:0] v);
    host.wr(32'h0, {28'h0, v}, resp);
    `CHK("ctrl write resp", swd_pkg::SWD_RESP_OKAY, resp);
  endtask : ctl

  task automatic rd_ctl();
    host.rd(32'h0, rdat, resp);
  endtask : rd_ctl

  // pulse is already up by the time the write returns; the wait lets the count catch up
  task automatic pulses(input int e);
    idle(3);
    `CHK("reset pulses", e, n_pulse);
  endtask : pulses

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    i_sys_rst = 1'b1;
    chip = swd_pkg::SWD_CHIP_NORMAL;
    pin = 1'b0;
    ext_irq = 1'b0;
    idle(3);
    i_sys_rst <= 1'b0;
    idle(2);
    // table of mode selections
    for (int i = 0; i < 8; i++) begin
      setm(swd_pkg::swd_chip_mode_t'(rows[i].chip), rows[i].pin, 1'b0);
      ctl({rows[i].wd_mode_ctrl, 3'h0});
      rd_ctl();
      `CHK("wd mode", rows[i].mode, rdat[6:4]);
    end
    // mid-run reset back to normal, window mode
    setm(swd_pkg::SWD_CHIP_NORMAL, 1'b0, 1'b0);
    i_sys_rst <= 1'b1;
    idle(3);
    i_sys_rst <= 1'b0;
    idle(2);
    rd_ctl();
    `CHK("ctrl after reset", 32'h24, rdat);
    host.rd(32'h4, rdat, resp);
    `CHK("irq after reset", 32'h0, rdat);
    host.rd(32'h10, rdat, resp);
    `CHK("unmapped resp", swd_pkg::SWD_RESP_SLVERR, resp);
    // window: open-window triggers, then one too early
    idle(300);
    ctl(4'h0);
    pulses(0);
    rd_ctl();
    `CHK("period code", 32'h20, rdat);
    idle(20);
    ctl(4'h0);
    pulses(0);
    ctl(4'h0);
    pulses(1);
    rd_ctl();
    `CHK("code restored", 32'h24, rdat);
    // window overflow
    idle(300);
    ctl(4'h0);
    idle(40);
    pulses(2);
    // mode bit change in normal, then timeout behaviour
    // wait into the open window so only the mode bit change can cause the reset
    idle(260);
    ctl(4'h8);
    pulses(3);
    host.rd(32'h8, rdat, resp);
    `CHK("reset cause", 32'h104, rdat);
    idle(300);
    ctl(4'h8);
    ctl(4'h8);
    pulses(3);
    idle(33);
    `CHK("cyclic flag set", 1'b1, ci_flag);
    pulses(3);
    idle(33);
    pulses(4);
    host.wr(32'h4, 32'h0, resp);
    idle(2);
    `CHK("flag kept", 1'b1, ci_flag);
    host.wr(32'h4, 32'h1, resp);
    idle(2);
    `CHK("flag cleared", 1'b0, ci_flag);
    // disable pin edges in normal
    setm(swd_pkg::SWD_CHIP_NORMAL, 1'b1, 1'b0);
    pulses(5);
    setm(swd_pkg::SWD_CHIP_NORMAL, 1'b0, 1'b0);
    pulses(6);
    // standby with interrupt pending: bit cleared, writes to it ignored
    setm(swd_pkg::SWD_CHIP_STANDBY, 1'b0, 1'b1);
    rd_ctl();
    `CHK("irq re-enables", 4'h8, rdat[6:3]);
    ctl(4'h8);
    rd_ctl();
    `CHK("bit write ignored", 4'h8, rdat[6:3]);
    setm(swd_pkg::SWD_CHIP_STANDBY, 1'b0, 1'b0);
    ctl(4'h8);
    rd_ctl();
    `CHK("standby off", 4'h3, rdat[6:3]);
    setm(swd_pkg::SWD_CHIP_STANDBY, 1'b0, 1'b1);
    rd_ctl();
    `CHK("back to timeout", 4'h8, rdat[6:3]);
    pulses(6);
    // disable pin edge in standby also resets
    setm(swd_pkg::SWD_CHIP_STANDBY, 1'b1, 1'b1);
    pulses(7);
    complete_run();
  end
endmodule : testbench
